// file: include/etc_pkg.sv
// package: register map, field layout and enumerations of the eight-bit compare timer
package etc_pkg;

	// register byte offsets
	localparam logic [4:0] ETC_OFF_CTRL    = 5'h00;
	localparam logic [4:0] ETC_OFF_COUNT   = 5'h04;
	localparam logic [4:0] ETC_OFF_COMPARE = 5'h08;
	localparam logic [4:0] ETC_OFF_FLAGS   = 5'h0C;
	localparam logic [4:0] ETC_OFF_IRQEN   = 5'h10;
	localparam logic [4:0] ETC_OFF_STATUS  = 5'h14;

	// field positions inside the control register
	localparam int ETC_CS_LSB   = 0;
	localparam int ETC_WGM_LSB  = 3;
	localparam int ETC_COM_LSB  = 5;
	localparam int ETC_FORCE_BIT = 7;

	// flag and enable bit positions
	localparam int ETC_CMP_BIT = 0;
	localparam int ETC_OVF_BIT = 1;

	// values after reset and counter limits
	localparam logic [7:0] ETC_RST_COUNT   = 8'h00;
	localparam logic [7:0] ETC_RST_COMPARE = 8'h00;
	localparam logic [7:0] ETC_CNT_MAX     = 8'hFF;
	localparam logic [7:0] ETC_CNT_BOTTOM  = 8'h00;

	// axi responses
	localparam logic [1:0] ETC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ETC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ETC_WGM_NORMAL = 2'h0,
		ETC_WGM_PCPWM  = 2'h1,
		ETC_WGM_CTC    = 2'h2,
		ETC_WGM_FAST   = 2'h3
	} etc_wgm_t;

	typedef enum logic [1:0] {
		ETC_COM_OFF    = 2'h0,
		ETC_COM_TOGGLE = 2'h1,
		ETC_COM_CLEAR  = 2'h2,
		ETC_COM_SET    = 2'h3
	} etc_com_t;

	typedef struct packed {
		etc_com_t   compare_output_action;
		etc_wgm_t   waveform_mode;
		logic [2:0] clock_source_select;
	} etc_ctrl_t;

endpackage

// file: rtl/etc_timer.sv
// eight-bit timer/counter with one compare channel behind an axi4-lite slave
`timescale 1ns/1ps

// Operation
// [R1] each tick clears, increments or decrements the counter per mode and direction
// [R2] clock source select zero stops the counter, no ticks at all
// [R3] software reads and writes the counter at any time
// [R4] a software counter write beats any hardware clear or count that cycle
// [R5] counter and active compare value are compared all the time
// [R6] compare flag sets on the tick after the match is present
// [R7] flag with enable raises interrupt; service or write-one clears the flag
// [R8] pwm modes buffer compare value to top or bottom; others write directly
// [R9] compare accesses go to the buffer when buffering, else to active value
// [R10] force strobe in non-pwm acts on output only, no flag, no counter effect
// [R11] counter write blocks any compare match on the next tick
// [R12] software avoids writing counter equal compare, or zero when counting down
// [R13] waveform output state holds across waveform mode changes
// [R14] compare output action is not buffered, applies from next match
// [R15] nonzero compare output action puts waveform output on pin; direction stays
// [R16] compare output action zero leaves waveform output untouched on matches
// [R17] count sequence depends on waveform mode only, never on output action
// [R18] normal mode always counts up, wraps from ff to 00
// [R19] overflow flag sets as counter becomes zero; service or write-one clears it; the code sets it on reaching ff in fast pwm and not on a ctc clear
// [R20] mode two clears the counter when it equals the compare value
// [R21] mode three counts zero to ff and restarts from zero
// [R22] mode one counts up to ff and back down to zero repeatedly
// [R23] reset zeroes counter, compare, output, flags and control: stopped, no override
module etc_timer
	import etc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// tick enables from an outside prescaler, same clock, sources 2..7
	input  wire logic [5:0]  tick_src,
	// interrupt requests and service acknowledges
	output logic             irq_compare,
	input  wire logic        irq_compare_ack,
	output logic             irq_overflow,
	input  wire logic        irq_overflow_ack,
	// port pin logic
	input  wire logic        port_data,
	input  wire logic        output_pin_direction,
	output logic             pin_out,
	output logic             pin_oe
);

	// write and read channel holding registers
	logic        aw_v_ff;
	logic [4:0]  aw_a_ff;
	logic        w_v_ff;
	logic [7:0]  w_d_ff;
	logic        w_s_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	// timer state
	etc_ctrl_t   ctrl_ff;
	logic [7:0]  counter_value_ff;
	logic [7:0]  nxt_counter_value;
	logic        down_ff;
	logic        nxt_down;
	logic [7:0]  compare_value_ff;
	logic [7:0]  compare_buf_ff;
	logic        compare_match_flag_ff;
	logic        overflow_flag_ff;
	logic        compare_irq_enable_ff;
	logic        overflow_irq_enable_ff;
	logic        block_ff;
	logic        waveform_output_ff;
	logic        nxt_waveform_output;

	// decoded strobes
	logic        do_wr;
	logic        wr_ctrl;
	logic        wr_count;
	logic        wr_compare;
	logic        wr_flags;
	logic        wr_irqen;
	logic        wr_hit;
	logic        timer_tick;
	logic        pwm_mode;
	logic        match;
	logic        force_cmp;
	logic        top_reload;
	logic        ovf_set;
	logic [31:0] rd_mux;
	logic        rd_hit;

	// axi write: address and data are taken in either order, then one response
	assign s_axi_awready = !aw_v_ff;
	assign s_axi_wready  = !w_v_ff;
	assign do_wr         = aw_v_ff && w_v_ff && !bvalid_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_v_ff <= 1'b0;
			aw_a_ff <= 5'h00;
		end else if (s_axi_awvalid && !aw_v_ff) begin
			aw_v_ff <= 1'b1;
			aw_a_ff <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_v_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			w_v_ff <= 1'b0;
			w_d_ff <= 8'h00;
			w_s_ff <= 1'b0;
		end else if (s_axi_wvalid && !w_v_ff) begin
			w_v_ff <= 1'b1;
			w_d_ff <= s_axi_wdata[7:0];
			w_s_ff <= s_axi_wstrb[0];
		end else if (do_wr) begin
			w_v_ff <= 1'b0;
		end
	end

	// only the low byte lane holds register bits
	assign wr_hit     = do_wr && w_s_ff;
	assign wr_ctrl    = wr_hit && (aw_a_ff == ETC_OFF_CTRL);
	assign wr_count   = wr_hit && (aw_a_ff == ETC_OFF_COUNT);
	assign wr_compare = wr_hit && (aw_a_ff == ETC_OFF_COMPARE);
	assign wr_flags   = wr_hit && (aw_a_ff == ETC_OFF_FLAGS);
	assign wr_irqen   = wr_hit && (aw_a_ff == ETC_OFF_IRQEN);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= ETC_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (aw_a_ff == ETC_OFF_CTRL || aw_a_ff == ETC_OFF_COUNT ||
				aw_a_ff == ETC_OFF_COMPARE || aw_a_ff == ETC_OFF_FLAGS ||
				aw_a_ff == ETC_OFF_IRQEN || aw_a_ff == ETC_OFF_STATUS) ?
				ETC_RESP_OKAY : ETC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// axi read: one cycle after the address is taken
	assign s_axi_arready = !rvalid_ff;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			ETC_OFF_CTRL:    rd_mux[6:0] = ctrl_ff;
			ETC_OFF_COUNT:   rd_mux[7:0] = counter_value_ff; // [R3]
			ETC_OFF_COMPARE: rd_mux[7:0] = pwm_mode ? compare_buf_ff : compare_value_ff; // [R9]
			ETC_OFF_FLAGS:   rd_mux[1:0] = {overflow_flag_ff, compare_match_flag_ff};
			ETC_OFF_IRQEN:   rd_mux[1:0] = {overflow_irq_enable_ff, compare_irq_enable_ff};
			ETC_OFF_STATUS:  rd_mux[1:0] = {down_ff, waveform_output_ff};
			default:         rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= ETC_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_hit ? ETC_RESP_OKAY : ETC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// control and enable registers; the force bit is a strobe and never stored
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_ff <= '0; // [R23]
		end else if (wr_ctrl) begin
			ctrl_ff <= w_d_ff[6:0]; // [R14]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			compare_irq_enable_ff  <= 1'b0;
			overflow_irq_enable_ff <= 1'b0;
		end else if (wr_irqen) begin
			compare_irq_enable_ff  <= w_d_ff[ETC_CMP_BIT];
			overflow_irq_enable_ff <= w_d_ff[ETC_OVF_BIT];
		end
	end

	// tick selection: source 1 is every system cycle
	always_comb begin
		timer_tick = 1'b0;
		if (ctrl_ff.clock_source_select == 3'h1) begin
			timer_tick = 1'b1;
		end else if (ctrl_ff.clock_source_select != 3'h0) begin // [R2]
			timer_tick = tick_src[ctrl_ff.clock_source_select - 3'h2];
		end
	end

	assign pwm_mode = (ctrl_ff.waveform_mode == ETC_WGM_PCPWM) ||
		(ctrl_ff.waveform_mode == ETC_WGM_FAST);

	// next count from waveform mode, direction and, in ctc, the compare value
	always_comb begin
		nxt_down          = 1'b0;
		nxt_counter_value = counter_value_ff + 8'h01; // [R17]
		unique case (ctrl_ff.waveform_mode)
			ETC_WGM_NORMAL: nxt_counter_value = counter_value_ff + 8'h01; // [R18]
			ETC_WGM_FAST:   nxt_counter_value = counter_value_ff + 8'h01; // [R21]
			ETC_WGM_CTC: begin
				if (counter_value_ff == compare_value_ff) begin
					nxt_counter_value = ETC_CNT_BOTTOM; // [R20]
				end
			end
			ETC_WGM_PCPWM: begin
				nxt_down = down_ff ? (counter_value_ff != ETC_CNT_BOTTOM) :
					(counter_value_ff == ETC_CNT_MAX); // [R22]
				nxt_counter_value = nxt_down ? counter_value_ff - 8'h01 :
					counter_value_ff + 8'h01;
			end
		endcase
	end

	// software write wins over the tick
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			counter_value_ff <= ETC_RST_COUNT;
		end else if (wr_count) begin
			counter_value_ff <= w_d_ff; // [R4]
		end else if (timer_tick) begin
			counter_value_ff <= nxt_counter_value; // [R1]
		end
	end

	// direction survives a counter write so a running slope is not reversed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			down_ff <= 1'b0;
		end else if (timer_tick && !wr_count) begin
			down_ff <= nxt_down;
		end
	end

	// a counter write blocks matches until the next tick has gone by
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			block_ff <= 1'b0;
		end else if (wr_count) begin
			block_ff <= 1'b1; // [R11]
		end else if (timer_tick) begin
			block_ff <= 1'b0;
		end
	end

	assign match = (counter_value_ff == compare_value_ff) && !block_ff; // [R5]

	// buffer reload at top: fast pwm wraps at max, phase correct turns at max
	assign top_reload = timer_tick && !wr_count && (counter_value_ff == ETC_CNT_MAX);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			compare_buf_ff <= ETC_RST_COMPARE;
		end else if (wr_compare) begin
			compare_buf_ff <= w_d_ff; // [R9]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			compare_value_ff <= ETC_RST_COMPARE;
		end else if (wr_compare && !pwm_mode) begin
			compare_value_ff <= w_d_ff; // [R8]
		end else if (pwm_mode && top_reload) begin
			compare_value_ff <= compare_buf_ff; // [R8]
		end
	end

	// flags: a hardware set wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			compare_match_flag_ff <= 1'b0;
		end else if (timer_tick && match) begin
			compare_match_flag_ff <= 1'b1; // [R6]
		end else if (irq_compare_ack || (wr_flags && w_d_ff[ETC_CMP_BIT])) begin
			compare_match_flag_ff <= 1'b0; // [R7]
		end
	end

	// overflow: wraps from max to zero in normal and ctc, becomes zero at bottom in phase correct; reaches max in fast pwm
	assign ovf_set = timer_tick && !wr_count &&
		((ctrl_ff.waveform_mode == ETC_WGM_FAST) ? (nxt_counter_value == ETC_CNT_MAX) :
		((nxt_counter_value == ETC_CNT_BOTTOM) &&
		((ctrl_ff.waveform_mode == ETC_WGM_PCPWM) || (counter_value_ff == ETC_CNT_MAX))));

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overflow_flag_ff <= 1'b0;
		end else if (ovf_set) begin
			overflow_flag_ff <= 1'b1; // [R19]
		end else if (irq_overflow_ack || (wr_flags && w_d_ff[ETC_OVF_BIT])) begin
			overflow_flag_ff <= 1'b0;
		end
	end

	assign irq_compare  = compare_match_flag_ff && compare_irq_enable_ff; // [R7]
	assign irq_overflow = overflow_flag_ff && overflow_irq_enable_ff;

	// force uses the action being written in the same access
	assign force_cmp = wr_ctrl && w_d_ff[ETC_FORCE_BIT] && !pwm_mode; // [R10]

	// waveform generator; mode switches never touch the output state
	always_comb begin
		nxt_waveform_output = waveform_output_ff; // [R13]
		if (force_cmp) begin
			unique case (etc_com_t'(w_d_ff[6:5]))
				ETC_COM_OFF:    nxt_waveform_output = waveform_output_ff;
				ETC_COM_TOGGLE: nxt_waveform_output = !waveform_output_ff;
				ETC_COM_CLEAR:  nxt_waveform_output = 1'b0;
				ETC_COM_SET:    nxt_waveform_output = 1'b1;
			endcase
		end else if (timer_tick && ctrl_ff.compare_output_action != ETC_COM_OFF) begin // [R16]
			unique case (ctrl_ff.waveform_mode)
				ETC_WGM_NORMAL, ETC_WGM_CTC: begin
					if (match) begin
						nxt_waveform_output =
							(ctrl_ff.compare_output_action == ETC_COM_TOGGLE) ?
							!waveform_output_ff :
							(ctrl_ff.compare_output_action == ETC_COM_SET);
					end
				end
				ETC_WGM_FAST: begin
					if (ctrl_ff.compare_output_action == ETC_COM_TOGGLE) begin
						if (match) begin
							nxt_waveform_output = !waveform_output_ff;
						end
					end else if (match) begin
						nxt_waveform_output = (ctrl_ff.compare_output_action == ETC_COM_SET);
					end else if (top_reload) begin
						nxt_waveform_output = (ctrl_ff.compare_output_action == ETC_COM_CLEAR);
					end
				end
				ETC_WGM_PCPWM: begin
					// toggle is reserved here and does nothing
					if (match && ctrl_ff.compare_output_action != ETC_COM_TOGGLE) begin
						nxt_waveform_output = down_ff ^
							(ctrl_ff.compare_output_action == ETC_COM_SET);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			waveform_output_ff <= 1'b0;
		end else begin
			waveform_output_ff <= nxt_waveform_output;
		end
	end

	// port override; direction always belongs to the port
	assign pin_out = (ctrl_ff.compare_output_action != ETC_COM_OFF) ?
		waveform_output_ff : port_data; // [R15]
	assign pin_oe  = output_pin_direction;

	sequence s_cnt_write;
		wr_count;
	endsequence

	sequence s_no_match_next;
		##1 !match;
	endsequence

	AST_STOPPED: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
		(ctrl_ff.clock_source_select == 3'h0 && !wr_count) |=> $stable(counter_value_ff))
		else $error("counter moved while stopped");

	AST_WRITE_WINS: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
		wr_count |=> (counter_value_ff == $past(w_d_ff)))
		else $error("counter write lost to hardware");

	AST_FLAG_NEXT: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
		(timer_tick && match) |=> compare_match_flag_ff)
		else $error("compare flag not set after match");

	AST_BLOCK: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
		s_cnt_write |-> s_no_match_next)
		else $error("match seen right after counter write");

	AST_NORMAL_WRAP: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
		(timer_tick && !wr_count && ctrl_ff.waveform_mode == ETC_WGM_NORMAL &&
		counter_value_ff == ETC_CNT_MAX) |=> (counter_value_ff == 8'h00 && overflow_flag_ff))
		else $error("normal mode wrap or overflow wrong");

	AST_OVERRIDE: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
		(ctrl_ff.compare_output_action != ETC_COM_OFF) |-> (pin_out == waveform_output_ff))
		else $error("pin not overridden by waveform output");

	AST_COM_OFF: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
		(ctrl_ff.compare_output_action == ETC_COM_OFF && !force_cmp) |=>
		$stable(waveform_output_ff))
		else $error("waveform output changed with action off");

	AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
		irq_compare == (compare_match_flag_ff && compare_irq_enable_ff))
		else $error("compare interrupt disagrees with flag and enable");

	AST_DIRECT_CMP: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
		(wr_compare && !pwm_mode) |=> (compare_value_ff == $past(w_d_ff)))
		else $error("non-pwm compare write not direct");

	AST_FORCE_NOFLAG: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
		(force_cmp && !(timer_tick && match) && !compare_match_flag_ff) |=>
		!compare_match_flag_ff)
		else $error("force strobe set the compare flag");

endmodule

// file: dv/etc_port_model.sv
// port pin partner: port data, direction bit and the resolved pin level
`timescale 1ns/1ps
module etc_port_model (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// requests from the bench acting as software
	input  wire logic data_req,
	input  wire logic dir_req,
	// pin from the timer
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// port side
	output logic      port_data,
	output logic      output_pin_direction,
	output logic      pin_level
);
	logic last_ff;

	// port registers start as input with data low, like a fresh port
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			port_data            <= 1'h0;
			output_pin_direction <= 1'h0;
		end else begin
			port_data            <= data_req;
			output_pin_direction <= dir_req;
		end
	end

	// a released pin floats, so show the inverse of the last driven level
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last_ff <= 1'h0;
		end else if (pin_oe) begin
			last_ff <= pin_out;
		end
	end

	assign pin_level = pin_oe ? pin_out : ~last_ff;
endmodule

// file: dv/etc_timer_bench.sv
// self-checking bench for the eight-bit compare timer
`timescale 1ns/1ps
module etc_timer_bench
	import etc_pkg::*;
;
	logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, irq_compare, irq_compare_ack, irq_overflow, irq_overflow_ack;
	logic        port_data, output_pin_direction, pin_out, pin_oe, pin_level, data_req, dir_req;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [5:0]  tick_src;
	logic [33:0] exp_r[$];
	logic [1:0]  exp_b[$];
	logic [7:0]  v;
	logic [1:0]  acts[4];
	logic        oexp[4];
	int          failures, check_count, seed;

	etc_timer u_etc_timer (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tick_src, .irq_compare, .irq_compare_ack,
		.irq_overflow, .irq_overflow_ack, .port_data, .output_pin_direction, .pin_out, .pin_oe);

	etc_port_model u_etc_port_model (.clk_sys, .rst, .data_req, .dir_req, .pin_out, .pin_oe,
		.port_data, .output_pin_direction, .pin_level);

	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wg,
		input logic [1:0] cm, input logic fc);
		return {fc, cm, wg, cs};
	endfunction

	// handshakes are judged at the falling edge, where readies have settled
	task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw_p, w_p, aw_t, w_t, b_t;
		exp_b.push_back(r);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		aw_p = 1'h1;
		w_p  = 1'h1;
		while (aw_p || w_p) begin
			@(negedge clk_sys);
			aw_t = aw_p && s_axi_awready;
			w_t  = w_p && s_axi_wready;
			@(posedge clk_sys);
			if (aw_t) begin
				s_axi_awvalid <= 1'h0;
				aw_p = 1'h0;
			end
			if (w_t) begin
				s_axi_wvalid <= 1'h0;
				w_p = 1'h0;
			end
		end
		do begin
			@(negedge clk_sys);
			b_t = s_axi_bvalid;
			@(posedge clk_sys);
		end while (b_t !== 1'h1);
	endtask

	task automatic axi_rd(input logic [4:0] a, input logic [33:0] e);
		logic t;
		exp_r.push_back(e);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(negedge clk_sys);
			t = s_axi_arready;
			@(posedge clk_sys);
		end while (t !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do begin
			@(negedge clk_sys);
			t = s_axi_rvalid;
			@(posedge clk_sys);
		end while (t !== 1'h1);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			tick_src <= {5'($random(seed)), 1'h1};
			@(posedge clk_sys);
			tick_src <= 6'h00;
			@(posedge clk_sys);
		end
	endtask

	// ready is held high, so every valid seen here is taken at the next edge
	always @(negedge clk_sys) begin
		if (s_axi_rvalid === 1'h1 && exp_r.size() > 0) begin
			check("read", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
		end
		if (s_axi_bvalid === 1'h1 && exp_b.size() > 0) begin
			check("bresp", 34'(s_axi_bresp), 34'(exp_b.pop_front()));
		end
	end

	initial begin
		#(100 * 20000);
		failures++;
		give_verdict();
	end

	initial begin
		seed = 32'hd741;
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready, irq_compare_ack, irq_overflow_ack} = 4'hC;
		{data_req, dir_req, s_axi_awaddr, s_axi_araddr} = 12'h000;
		{s_axi_wdata, s_axi_wstrb, tick_src} = {32'h0, 4'hF, 6'h00};
		acts = '{2'h1, 2'h0, 2'h2, 2'h3};
		oexp = '{1'h1, 1'h1, 1'h0, 1'h1};
		repeat (12) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		for (int i = 0; i < 6; i++) axi_rd(5'(4 * i), {ETC_RESP_OKAY, 32'h0});
		axi_rd(5'h18, {ETC_RESP_SLVERR, 32'h0});
		axi_wr(5'h1C, 8'h55, ETC_RESP_SLVERR);
		@(negedge clk_sys);
		check("pin_out", pin_out, port_data);
		check("irq", {irq_compare, irq_overflow}, 2'h0);
		@(posedge clk_sys);
		v = 8'h10 + 8'($random(seed) & 32'h7F);
		axi_wr(ETC_OFF_COUNT, v, ETC_RESP_OKAY);
		tick(3);
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 24'h0, v});
		axi_wr(ETC_OFF_IRQEN, 8'h03, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COMPARE, v, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_CTRL, ctl(3'h2, ETC_WGM_NORMAL, ETC_COM_OFF, 1'h0), ETC_RESP_OKAY);
		// counter written equal to compare on purpose: the match must be lost
		axi_wr(ETC_OFF_COUNT, v, ETC_RESP_OKAY);
		tick(1);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 24'h0, v + 8'h01});
		axi_wr(ETC_OFF_COUNT, v - 8'h01, ETC_RESP_OKAY);
		tick(1);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		tick(1);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h1});
		@(negedge clk_sys);
		check("irq_compare", irq_compare, 1'h1);
		@(posedge clk_sys);
		irq_compare_ack <= 1'h1;
		@(posedge clk_sys);
		irq_compare_ack <= 1'h0;
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		axi_wr(ETC_OFF_COUNT, v - 8'h01, ETC_RESP_OKAY);
		tick(2);
		axi_wr(ETC_OFF_FLAGS, 8'h01, ETC_RESP_OKAY);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		axi_wr(ETC_OFF_COUNT, 8'hFE, ETC_RESP_OKAY);
		tick(2);
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'h0});
		tick(1);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h2});
		@(negedge clk_sys);
		check("irq_overflow", irq_overflow, 1'h1);
		@(posedge clk_sys);
		irq_overflow_ack <= 1'h1;
		@(posedge clk_sys);
		irq_overflow_ack <= 1'h0;
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		// ticks run every cycle across the counter write, so both land together
		tick_src <= 6'h01;
		axi_wr(ETC_OFF_COUNT, 8'h30, ETC_RESP_OKAY);
		tick_src <= 6'h00;
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'h31});
		for (int i = 0; i < 4; i++) begin
			data_req <= 1'($random(seed));
			dir_req  <= 1'($random(seed));
			axi_wr(ETC_OFF_CTRL, ctl(3'h0, ETC_WGM_NORMAL, acts[i], 1'h1), ETC_RESP_OKAY);
			axi_rd(ETC_OFF_STATUS, {ETC_RESP_OKAY, 31'h0, oexp[i]});
			@(negedge clk_sys);
			check("pin_out", pin_out, (acts[i] != 2'h0) ? oexp[i] : port_data);
			check("pin_oe", pin_oe, output_pin_direction);
			@(posedge clk_sys);
		end
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'h31});
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h0});
		axi_wr(ETC_OFF_CTRL, ctl(3'h0, ETC_WGM_CTC, ETC_COM_OFF, 1'h0), ETC_RESP_OKAY);
		axi_wr(ETC_OFF_CTRL, ctl(3'h0, ETC_WGM_FAST, ETC_COM_OFF, 1'h0), ETC_RESP_OKAY);
		axi_rd(ETC_OFF_STATUS, {ETC_RESP_OKAY, 32'h1});
		axi_wr(ETC_OFF_CTRL, ctl(3'h2, ETC_WGM_CTC, ETC_COM_TOGGLE, 1'h0), ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COMPARE, 8'h05, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COUNT, 8'h03, ETC_RESP_OKAY);
		tick(3);
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'h0});
		axi_rd(ETC_OFF_STATUS, {ETC_RESP_OKAY, 32'h0});
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h1});
		axi_wr(ETC_OFF_FLAGS, 8'h01, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_CTRL, ctl(3'h2, ETC_WGM_FAST, ETC_COM_OFF, 1'h0), ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COMPARE, 8'h20, ETC_RESP_OKAY);
		axi_rd(ETC_OFF_COMPARE, {ETC_RESP_OKAY, 32'h20});
		axi_wr(ETC_OFF_COUNT, 8'h04, ETC_RESP_OKAY);
		tick(2);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h1});
		axi_wr(ETC_OFF_FLAGS, 8'h01, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COUNT, 8'hFE, ETC_RESP_OKAY);
		tick(2);
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'h0});
		axi_wr(ETC_OFF_COUNT, 8'h1F, ETC_RESP_OKAY);
		tick(2);
		axi_rd(ETC_OFF_FLAGS, {ETC_RESP_OKAY, 32'h3});
		axi_wr(ETC_OFF_FLAGS, 8'h03, ETC_RESP_OKAY);
		axi_wr(ETC_OFF_CTRL, ctl(3'h2, ETC_WGM_PCPWM, ETC_COM_CLEAR, 1'h0), ETC_RESP_OKAY);
		axi_wr(ETC_OFF_COUNT, 8'hFE, ETC_RESP_OKAY);
		tick(3);
		axi_rd(ETC_OFF_COUNT, {ETC_RESP_OKAY, 32'hFD});
		axi_rd(ETC_OFF_STATUS, {ETC_RESP_OKAY, 32'h2});
		repeat (4) @(posedge clk_sys);
		check("pending", 34'(exp_r.size() + exp_b.size()), 34'h0);
		give_verdict();
	end
endmodule
